// ### rsi_defs.svh
// Notes on behaviour
// RULE1: Outside agent holds hard or soft reset input low 32 bus periods.
// RULE2: Host mode: power-on reset held 32 primary clock periods, clock stable.
// RULE3: Agent mode: power-on reset held 32 bus clock periods, clock stable.
// RULE4: Driven hard and soft resets stay asserted at least 512 bus periods.
// RULE5: Soft reset released no sooner than 16 bus periods after hard.
// RULE6: Host mode: board sets straps 4 primary periods before power-on release.
// RULE7: Agent mode: board sets straps 4 bus periods before power-on release.
// RULE8: Strap pins released as soon as hard reset is asserted.
// RULE9: Strap pins driven again no sooner than 1 bus period after hard release.
// RULE10: Sampled configuration is a 3-bit reset source and one divide bit.
// RULE11: Host mode bus period follows primary clock and the divide strap.
// RULE12: Lock wait lasts between 7680 and 122880 system bus cycles.
// RULE13: Software keeps engine core clock above each interface minimum.
// RULE14: Primary clock is the input clock in host, bus clock in agent.
// RULE15: Shorter reset pulses are ignored; qualification counts on reference clock.
`ifndef RSI_DEFS_SVH
`define RSI_DEFS_SVH

// ****************************************
// Timing figures, in bus or reference clock periods, or in ns
// ****************************************
`define RSI_CLK_NS 40
`define RSI_QUAL_LEN 6'h20
`define RSI_QUAL_W 6
`define RSI_HOLD_LEN 10'h200
`define RSI_HOLD_W 10
`define RSI_GAP_LEN 10'h010
`define RSI_STRAP_ON_LEN 10'h001
`define RSI_STRAP_OFF_NS 4
// Readback of a just-released reset pin stays low for 3 cycles (sync + clear)
`define RSI_SETTLE_LEN 10'h004
`define RSI_DLL_MIN 7680
`define RSI_DLL_MAX 122880
`define RSI_DLL_W 17

// ****************************************
// Strap field layout
// ****************************************
`define RSI_SRC_W 3
`define RSI_STRAP_W 4
`define RSI_STRAP_DIV_BIT 3

`endif

// ### rsi_pkg.sv
`include "rsi_defs.svh"

package rsi_pkg;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    RSI_ST_POR,
    RSI_ST_DLL,
    RSI_ST_HOLD,
    RSI_ST_GAP,
    RSI_ST_SOFT,
    RSI_ST_RUN
  } rsi_state_t;

  // Sampled power-on configuration
  typedef struct packed {
    logic [`RSI_SRC_W-1:0] src;
    logic div;
  } rsi_cfg_t;

  // Qualifier state
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [`RSI_QUAL_W-1:0] cnt;
    logic held;
  } rsi_qual_t;

  // Sequencer state
  typedef struct packed {
    rsi_state_t st;
    logic [`RSI_HOLD_W-1:0] cnt;
    logic [`RSI_DLL_W-1:0] dll_cnt;
    logic [`RSI_STRAP_W-1:0] strap_s1;
    logic [`RSI_STRAP_W-1:0] strap_s2;
    logic [1:0] host_s;
    logic [1:0] lock_s;
    logic host;
    logic phase;
    logic tick;
    logic por_seen;
    logic hard_drv;
    logic soft_drv;
    logic strap_oe;
    logic [`RSI_STRAP_W-1:0] strap_val;
    rsi_cfg_t cfg;
    logic dll_err;
    logic ready;
  } rsi_seq_t;

endpackage : rsi_pkg

// ### rsi_qual.sv
`timescale 1ns/1ps
`include "rsi_defs.svh"

module rsi_qual
  import rsi_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Reference tick and raw pin
  input wire logic i_tick,
  input wire logic i_pin_n,
  // Qualified assertion level
  output logic o_held
);

  rsi_qual_t s;
  rsi_qual_t next_s;

  // Two-stage sync, then count low ticks up to the minimum length
  always_comb begin
    next_s = s;
    next_s.sync1 = i_pin_n;
    next_s.sync2 = s.sync1;
    if (s.sync2) begin
      next_s.cnt = '0; // RULE15
      next_s.held = 1'b0;
    end else if (i_tick && s.cnt != `RSI_QUAL_LEN) begin
      next_s.cnt = s.cnt + 1'b1;
    end
    if (!s.sync2 && s.cnt == `RSI_QUAL_LEN) begin
      next_s.held = 1'b1; // RULE15
    end
  end

  // State register; pin idles high after reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s <= '{sync1: 1'b1, sync2: 1'b1, cnt: '0, held: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign o_held = s.held;

  // Held only after a full run of low ticks
  a_qual_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_held) |-> $past(s.cnt) == `RSI_QUAL_LEN && !$past(s.sync2))
    else $error("reset qualified before minimum length"); // RULE15

endmodule : rsi_qual

// ### rsi_init_seq.sv
`timescale 1ns/1ps
`include "rsi_defs.svh"

module rsi_init_seq
  import rsi_pkg::*;
#(
  parameter int DLL_MIN_CYC = `RSI_DLL_MIN,
  parameter int DLL_MAX_CYC = `RSI_DLL_MAX
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Reset pins from outside, active low
  input wire logic i_power_on_reset_n,
  input wire logic i_hard_reset_n,
  input wire logic i_soft_reset_n,
  // Mode strap and lock status
  input wire logic i_host_mode,
  input wire logic i_dll_lock,
  // Shared strap pins
  input wire logic [`RSI_STRAP_W-1:0] i_strap,
  input wire logic [`RSI_STRAP_W-1:0] i_strap_drive,
  output logic [`RSI_STRAP_W-1:0] o_strap,
  output logic o_strap_oe,
  // Open-drain reset outputs
  output logic o_hard_reset_n,
  output logic o_hard_reset_n_oe,
  output logic o_soft_reset_n,
  output logic o_soft_reset_n_oe,
  // Sampled configuration and status
  output logic [`RSI_SRC_W-1:0] o_cfg_reset_source,
  output logic o_input_clock_divide_strap,
  output logic o_bus_tick,
  output logic o_dll_err,
  output logic o_ready
);

  // ****************************************
  // State and qualifiers
  // ****************************************
  localparam logic [`RSI_DLL_W-1:0] DLL_MIN = `RSI_DLL_W'(DLL_MIN_CYC);
  localparam logic [`RSI_DLL_W-1:0] DLL_MAX = `RSI_DLL_W'(DLL_MAX_CYC);

  rsi_seq_t s;
  rsi_seq_t next_s;
  logic por_held;
  logic hard_held;
  logic soft_held;
  logic por_low;

  // Power-on counts every cycle: input clock in host, bus clock in agent
  rsi_qual u_por_qual (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(1'b1), // RULE2 RULE3
    .i_pin_n(i_power_on_reset_n),
    .o_held(por_held)
  );

  // Hard and soft inputs count bus periods
  rsi_qual u_hard_qual (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(s.tick), // RULE1
    .i_pin_n(i_hard_reset_n),
    .o_held(hard_held)
  );

  rsi_qual u_soft_qual (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(s.tick), // RULE1
    .i_pin_n(i_soft_reset_n),
    .o_held(soft_held)
  );

  // Power-on still low after qualification: the held flag drops on release
  assign por_low = por_held;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.strap_s1 = i_strap;
    next_s.strap_s2 = s.strap_s1;
    next_s.host_s = {s.host_s[0], i_host_mode};
    next_s.lock_s = {s.lock_s[0], i_dll_lock};
    next_s.strap_val = i_strap_drive;
    // Bus tick: every cycle in agent, halved in host when divide set
    next_s.phase = ~s.phase;
    next_s.tick = !s.host || !s.cfg.div || !s.phase; // RULE11 RULE14
    if (s.tick && s.cnt != {`RSI_HOLD_W{1'b1}}) begin
      next_s.cnt = s.cnt + 1'b1;
    end
    case (s.st)
      RSI_ST_POR: begin
        // Straps and mode follow the pins while power-on is low
        next_s.hard_drv = 1'b1;
        next_s.soft_drv = 1'b1;
        next_s.strap_oe = 1'b0;
        next_s.ready = 1'b0;
        if (por_low) begin
          next_s.por_seen = 1'b1;
          next_s.cfg.src = s.strap_s2[`RSI_SRC_W-1:0]; // RULE10
          next_s.cfg.div = s.strap_s2[`RSI_STRAP_DIV_BIT]; // RULE10
          next_s.host = s.host_s[1];
        end else if (s.por_seen) begin
          next_s.st = RSI_ST_DLL;
          next_s.dll_cnt = '0;
          next_s.dll_err = 1'b0;
        end
      end
      RSI_ST_DLL: begin
        // Lock wait bounded on both sides
        next_s.dll_cnt = s.dll_cnt + 1'b1;
        if ((s.lock_s[1] && s.dll_cnt >= DLL_MIN) ||
            s.dll_cnt >= DLL_MAX) begin // RULE12
          next_s.dll_err = !s.lock_s[1];
          next_s.st = RSI_ST_HOLD;
          next_s.cnt = '0;
        end
      end
      RSI_ST_HOLD: begin
        if (s.cnt >= `RSI_HOLD_LEN) begin // RULE4
          next_s.hard_drv = 1'b0;
          next_s.st = RSI_ST_GAP;
          next_s.cnt = '0;
        end
      end
      RSI_ST_GAP: begin
        if (s.cnt >= `RSI_STRAP_ON_LEN) begin
          next_s.strap_oe = 1'b1; // RULE9
        end
        if (s.cnt >= `RSI_GAP_LEN) begin // RULE5
          next_s.soft_drv = 1'b0;
          next_s.ready = 1'b1;
          next_s.st = RSI_ST_RUN;
          next_s.cnt = '0;
        end
      end
      RSI_ST_SOFT: begin
        if (s.cnt >= `RSI_HOLD_LEN) begin // RULE4
          next_s.soft_drv = 1'b0;
          next_s.ready = 1'b1;
          next_s.st = RSI_ST_RUN;
          next_s.cnt = '0;
        end
      end
      RSI_ST_RUN: begin
        // Own driven pins read back low, so inputs are only watched here;
        // a stale held flag from our own drive must not restart the flow
        if (s.cnt >= `RSI_SETTLE_LEN && hard_held) begin
          next_s.hard_drv = 1'b1;
          next_s.soft_drv = 1'b1;
          next_s.strap_oe = 1'b0; // RULE8
          next_s.ready = 1'b0;
          next_s.st = RSI_ST_HOLD;
          next_s.cnt = '0;
        end else if (s.cnt >= `RSI_SETTLE_LEN && soft_held) begin
          next_s.soft_drv = 1'b1;
          next_s.ready = 1'b0;
          next_s.st = RSI_ST_SOFT;
          next_s.cnt = '0;
        end
      end
      default: begin
        next_s.st = RSI_ST_POR;
      end
    endcase
    // Power-on overrides everything; straps released with hard reset
    if (por_low && s.st != RSI_ST_POR) begin
      next_s.st = RSI_ST_POR;
      next_s.por_seen = 1'b1;
      next_s.hard_drv = 1'b1;
      next_s.soft_drv = 1'b1;
      next_s.strap_oe = 1'b0; // RULE8
      next_s.ready = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s <= '0;
      s.st <= RSI_ST_POR;
      s.hard_drv <= 1'b1;
      s.soft_drv <= 1'b1;
      s.strap_s1 <= '0;
      s.host_s <= 2'h0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state; open-drain pins only pull low
  assign o_hard_reset_n = 1'b0;
  assign o_soft_reset_n = 1'b0;
  assign o_hard_reset_n_oe = s.hard_drv;
  assign o_soft_reset_n_oe = s.soft_drv;
  assign o_strap = s.strap_val;
  assign o_strap_oe = s.strap_oe;
  assign o_cfg_reset_source = s.cfg.src;
  assign o_input_clock_divide_strap = s.cfg.div;
  assign o_bus_tick = s.tick;
  assign o_dll_err = s.dll_err;
  assign o_ready = s.ready;

  // ****************************************
  // Checks
  // ****************************************
  logic [`RSI_HOLD_W-1:0] hold_ticks;
  logic [`RSI_HOLD_W-1:0] rel_ticks;

  // Helper counts of bus ticks while driven and since hard release
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !s.soft_drv) begin
      hold_ticks <= '0;
    end else if (s.tick && hold_ticks != {`RSI_HOLD_W{1'b1}}) begin
      hold_ticks <= hold_ticks + 1'b1;
    end
    if (i_sys_rst || s.hard_drv) begin
      rel_ticks <= '0;
    end else if (s.tick && rel_ticks != {`RSI_HOLD_W{1'b1}}) begin
      rel_ticks <= rel_ticks + 1'b1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_hard_gone;
    $fell(s.hard_drv) && !por_low;
  endsequence

  sequence s_soft_gone;
    $fell(s.soft_drv);
  endsequence

  a_hold_min: assert property (s_hard_gone |-> hold_ticks >= `RSI_HOLD_LEN)
    else $error("hard reset released too early"); // RULE4
  a_soft_gap: assert property (s_soft_gone |-> rel_ticks >= `RSI_GAP_LEN)
    else $error("soft reset released too soon after hard"); // RULE5
  a_strap_off: assert property (s.hard_drv |-> !s.strap_oe)
    else $error("strap pins driven during hard reset"); // RULE8
  a_strap_on: assert property ($rose(s.strap_oe) |->
    !s.hard_drv && rel_ticks >= `RSI_STRAP_ON_LEN)
    else $error("strap pins driven too soon"); // RULE9
  a_cfg_hold: assert property (s.ready |-> $stable(s.cfg))
    else $error("configuration changed while running"); // RULE10
  a_tick_half: assert property (s.host && s.cfg.div &&
    $stable({s.host, s.cfg.div}) && s.tick |=> !s.tick)
    else $error("bus tick too fast in divided host mode"); // RULE11
  a_tick_agent: assert property (!s.host && !$past(s.host) &&
    !$past(i_sys_rst) |-> s.tick)
    else $error("bus tick missing in agent mode"); // RULE14
  a_dll_bound: assert property (s.st == RSI_ST_DLL |-> s.dll_cnt <= DLL_MAX)
    else $error("lock wait overran"); // RULE12
  a_dll_min: assert property (s.st == RSI_ST_DLL ##1 s.st == RSI_ST_HOLD |->
    $past(s.dll_cnt) >= DLL_MIN)
    else $error("lock wait too short"); // RULE12

endmodule : rsi_init_seq

// ### rsi_board_model.sv
`timescale 1ns/1ps

module rsi_board_model (
  // Clock
  input wire logic i_clk,
  // Board strap resistors
  input wire logic [3:0] i_cfg,
  // Device side of the shared pins
  input wire logic i_hard_oe,
  input wire logic i_hard_val,
  input wire logic i_soft_oe,
  input wire logic i_soft_val,
  input wire logic i_strap_oe,
  input wire logic [3:0] i_strap,
  // Resolved pin levels
  output logic o_por_n,
  output logic o_hard_n,
  output logic o_soft_n,
  output logic [3:0] o_strap
);
  // Board pulls: 0 power-on, 1 hard, 2 soft
  logic [2:0] pulls = 3'h0;

  // Open drain: either party pulls hard or soft low, only the board pulls power-on; the pull-up gives high
  assign o_por_n = ~pulls[0];
  assign o_hard_n = ~((i_hard_oe & ~i_hard_val) | pulls[1]);
  assign o_soft_n = ~((i_soft_oe & ~i_soft_val) | pulls[2]);
  // Straps are static resistors, so valid long before release
  assign o_strap = i_strap_oe ? i_strap : i_cfg;

  // Hold a pin low a whole number of cycles, edges after the clock
  task automatic pulse(input int sel, input int n);
    begin
      @(posedge i_clk);
      pulls[sel] <= 1'b1;
      repeat (n) @(posedge i_clk);
      pulls[sel] <= 1'b0;
    end
  endtask : pulse
endmodule : rsi_board_model

// ### reset_init_sequencer_tb.sv
`timescale 1ns/1ps

module reset_init_sequencer_tb;
  import rsi_pkg::*;
  logic clk, sys_rst, host_mode, dll_lock;
  logic [3:0] cfg, strap_drive, strap_pin, strap_out;
  logic por_n, hard_n, soft_n, hard_v, soft_v;
  logic hard_oe, soft_oe, strap_oe, tick, dll_err, ready, div_out;
  logic [2:0] src_out;
  logic prev_hard, prev_soft, prev_so;
  logic [31:0] seed;
  logic [3:0] drive_q;
  int n_mismatch, checks_done, hold_t, soft_t, gap_t;

  rsi_init_seq #(.DLL_MIN_CYC(20), .DLL_MAX_CYC(60)) rsi_init_seq_inst (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_power_on_reset_n(por_n),
    .i_hard_reset_n(hard_n), .i_soft_reset_n(soft_n),
    .i_host_mode(host_mode), .i_dll_lock(dll_lock), .i_strap(strap_pin),
    .i_strap_drive(strap_drive), .o_strap(strap_out),
    .o_strap_oe(strap_oe), .o_hard_reset_n(hard_v),
    .o_hard_reset_n_oe(hard_oe), .o_soft_reset_n(soft_v),
    .o_soft_reset_n_oe(soft_oe), .o_cfg_reset_source(src_out),
    .o_input_clock_divide_strap(div_out), .o_bus_tick(tick),
    .o_dll_err(dll_err), .o_ready(ready));

  rsi_board_model board_inst (
    .i_clk(clk), .i_cfg(cfg), .i_hard_oe(hard_oe), .i_hard_val(hard_v),
    .i_soft_oe(soft_oe), .i_soft_val(soft_v), .i_strap_oe(strap_oe),
    .i_strap(strap_out), .o_por_n(por_n), .o_hard_n(hard_n),
    .o_soft_n(soft_n), .o_strap(strap_pin));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done++;
      if (seen !== exp) begin
        n_mismatch++;
        $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
      end
    end
  endtask : check

  task automatic stop_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask : stop_test

  // Fresh random straps, then a qualifying power-on pulse
  task automatic boot(input logic host, input logic div, input logic lock);
    begin
      seed = xs(seed);
      @(posedge clk);
      host_mode <= host;
      dll_lock <= lock;
      cfg <= {div, seed[2:0]};
      strap_drive <= seed[7:4];
      board_inst.pulse(0, 40);
    end
  endtask : boot

  // Bounded wait, then the sampled straps must match the board
  task automatic wait_ready(input int lim);
    int k;
    begin
      k = 0;
      while (ready !== 1'b1 && k < lim) begin
        @(negedge clk);
        k++;
      end
      check(ready, 1);
      check(dll_err, 0);
      check(src_out, cfg[2:0]);
      check(div_out, cfg[3]);
    end
  endtask : wait_ready

  // Distance in cycles between two bus ticks
  task automatic tick_gap(input int exp);
    int k;
    begin
      repeat (2) begin
        k = 0;
        do begin
          @(negedge clk);
          k++;
        end while (tick !== 1'b1 && k < 9);
      end
      check(k, exp);
    end
  endtask : tick_gap

  // ****************************************
  // Clock, monitor and watchdog
  // ****************************************
  // 25 MHz core clock, above the slowest interface minimum
  always #20 clk = ~clk;

  // Strap output model: the pin value follows the drive request one cycle on
  always @(posedge clk) drive_q <= strap_drive;

  // Tick counts over each driven phase; only lower bounds are fixed.
  // Sampled mid-cycle so that outputs have settled after the edge
  always @(negedge clk) begin
    if (!sys_rst) begin
      check({hard_v, soft_v}, 2'h0);
      if (hard_oe && !prev_hard) hold_t = 0;
      if (soft_oe && !prev_soft) soft_t = 0;
      if (hard_oe && tick) hold_t++;
      if (soft_oe && tick) soft_t++;
      if (!hard_oe && tick) gap_t++;
      if (!hard_oe && prev_hard) begin
        check(hold_t >= 512, 1);
        gap_t = 0;
      end
      if (!soft_oe && prev_soft) check(soft_t >= 512, 1);
      if (!soft_oe && prev_soft) check(gap_t >= 16, 1);
      if (strap_oe && !prev_so) check(gap_t >= 1, 1);
      if (strap_oe) check(strap_out, drive_q);
      if (hard_oe) check(strap_oe, 0);
    end
    prev_hard = hard_oe;
    prev_soft = soft_oe;
    prev_so = strap_oe;
  end

  // Whole run needs about 3200 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 0;
    sys_rst = 1;
    host_mode = 0;
    dll_lock = 0;
    cfg = 4'h0;
    strap_drive = 4'h0;
    seed = 32'h49249382;
    n_mismatch = 0;
    checks_done = 0;
    hold_t = 0;
    soft_t = 0;
    gap_t = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    boot(0, 0, 1);
    wait_ready(2000);
    tick_gap(1);
    // Short pulses on every reset pin must leave the device running
    for (int s = 0; s < 3; s++) begin
      board_inst.pulse(s, 20);
      repeat (40) @(negedge clk);
      check(ready, 1);
    end
    board_inst.pulse(1, 40);
    @(negedge clk);
    check(hard_oe, 1);
    wait_ready(2000);
    board_inst.pulse(2, 40);
    @(negedge clk);
    check({hard_oe, soft_oe}, 2'h1);
    wait_ready(2000);
    boot(1, 1, 1);
    wait_ready(3000);
    tick_gap(2);
    boot(0, 0, 0);
    repeat (100) @(negedge clk);
    check({dll_err, hard_oe}, 2'h3);
    stop_test;
  end
endmodule : reset_init_sequencer_tb
